// >>> hdl/gigabit_control_status_regs.sv
// gigabit control and status registers with pending configuration
// assumes negotiation logic supplies status and pulses synchronous
// to i_clk; idle error and fault events are one-cycle pulses
`timescale 1ns/100ps

// Summary of operation
// - test mode field 15:13, 000 normal, 001-100 tests, above 100 reserved
// - test modes 2 and 3 take transmit clock from receive clock
// - any negotiation restart returns test mode to zero
// - bits 12:8 stay pending until reset, restart, power-up or link loss
// - bit 12 one selects manual role, zero automatic resolution
// - under manual role bit 11 one forces master, zero slave
// - port type bit 10 prefers master; ignored when bit 12 is one
// - status bit 15 latches a role fault and clears on read
// - status bit 14 shows the resolved role, one for master
// - status bit 13 shows local receiver health
// - status bit 12 shows remote receiver health
// - status bits 11 and 10 show partner gigabit full and half ability
// - status bits 7:0 count idle errors since last read, read clears
// - idle error count saturates at all ones
// - leaving power down forces a software reset and a restart
module gigabit_control_status_regs (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  // register port
  input  wire logic [4:0]                i_addr,
  input  wire logic [15:0]               i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [15:0]               o_rdata,
  // control events
  input  wire logic                      i_soft_reset,
  input  wire logic                      i_an_restart,
  input  wire logic                      i_pd_main,
  input  wire logic                      i_pd_copper,
  input  wire logic                      i_link_down,
  // status inputs
  input  wire gig_regs_pkg::link_stat_s  i_link,
  input  wire logic                      i_role_fault,
  input  wire logic                      i_idle_error,
  // outputs to the transceiver core
  output gig_regs_pkg::gig_cfg_s         o_cfg,
  output logic      [2:0]                o_test_mode,
  output logic                           o_tx_clk_from_rx,
  output logic                           o_prefer_master,
  output logic                           o_force_master,
  output logic                           o_force_slave,
  output logic                           o_soft_reset,
  output logic                           o_an_restart
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]             ctrl;
  gig_regs_pkg::gig_cfg_s  active;
  logic                    fault;
  logic [7:0]              idle_cnt;
  logic                    pd_prev;

  // ----------------------------------------------------------------
  // decode and update events
  // ----------------------------------------------------------------
  wire logic ctrl_wr  = i_wr && (i_addr == gig_regs_pkg::CTRL_OFFSET);
  wire logic stat_rd  = i_rd && (i_addr == gig_regs_pkg::STAT_OFFSET);
  wire logic ctrl_rd  = i_rd && (i_addr == gig_regs_pkg::CTRL_OFFSET);
  wire logic pd_now   = i_pd_main || i_pd_copper;
  wire logic pd_exit  = pd_prev && !pd_now;
  wire logic do_soft  = i_soft_reset || pd_exit;
  wire logic do_rst   = i_an_restart || pd_exit;
  wire logic do_upd   = do_soft || do_rst || i_link_down;

  // write data with test mode; a restart clears it after the write
  wire logic [15:0] ctrl_wr_val = ctrl_wr ? i_wdata : ctrl;
  wire logic [15:0] next_ctrl   = do_rst
    ? {gig_regs_pkg::TM_NORMAL, ctrl_wr_val[12:0]}
    : ctrl_wr_val;

  // pending settings as written by software
  wire gig_regs_pkg::gig_cfg_s pend = '{
    manual_en:     next_ctrl[gig_regs_pkg::MAN_EN_BIT],
    manual_master: next_ctrl[gig_regs_pkg::MAN_VAL_BIT],
    port_master:   next_ctrl[gig_regs_pkg::PORT_TYPE_BIT],
    adv_full:      next_ctrl[gig_regs_pkg::ADV_FD_BIT],
    adv_half:      next_ctrl[gig_regs_pkg::ADV_HD_BIT]};

  // fault and counter: set wins over a read clear
  wire logic       next_fault = i_role_fault || (fault && !stat_rd);
  wire logic [7:0] cnt_base   = stat_rd ? 8'h00 : idle_cnt;
  wire logic       cnt_sat    = cnt_base == gig_regs_pkg::IDLE_MAX;
  wire logic [7:0] next_idle  = (i_idle_error && !cnt_sat)
    ? 8'(cnt_base + 8'h01) : cnt_base;

  // status word assembled from live inputs and latched events
  wire logic [15:0] stat_word = {
    fault,
    i_link.resolved_master,
    i_link.local_rx_ok,
    i_link.remote_rx_ok,
    i_link.lp_full, i_link.lp_half,
    2'b00,
    idle_cnt};

  wire logic [15:0] next_rdata = stat_rd ? stat_word
                               : ctrl_rd ? ctrl : 16'h0000;

  // ----------------------------------------------------------------
  // control register and applied settings
  // ----------------------------------------------------------------
  // hard reset loads defaults; soft reset leaves 15:13 and 7:0 alone
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl   <= gig_regs_pkg::CTRL_RESET;
      active <= gig_regs_pkg::gig_cfg_s'(5'b00011);
      pd_prev <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      pd_prev <= pd_now;
      if (do_upd) begin
        active <= pend;
      end
    end
  end

  // status event latches and read data
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fault    <= 1'b0;
      idle_cnt <= 8'h00;
      o_rdata  <= 16'h0000;
    end else begin
      fault    <= next_fault;
      idle_cnt <= next_idle;
      o_rdata  <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs to the core
  // ----------------------------------------------------------------
  // reserved codes above 4 run as normal operation
  assign o_test_mode = (ctrl[gig_regs_pkg::TM_HI:gig_regs_pkg::TM_LO]
                        > gig_regs_pkg::TM_MAX)
                     ? gig_regs_pkg::TM_NORMAL
                     : ctrl[gig_regs_pkg::TM_HI:gig_regs_pkg::TM_LO];
  assign o_tx_clk_from_rx = (o_test_mode == gig_regs_pkg::TM_JIT_MASTER)
                         || (o_test_mode == gig_regs_pkg::TM_JIT_SLAVE);
  assign o_cfg           = active;
  assign o_force_master  = active.manual_en && active.manual_master;
  assign o_force_slave   = active.manual_en && !active.manual_master;
  assign o_prefer_master = !active.manual_en && active.port_master;
  assign o_soft_reset    = do_soft;
  assign o_an_restart    = do_rst;

endmodule

// >>> hdl/gig_regs_pkg.sv
// package for the gigabit control and status register pair
// assumes a 16-bit register port with one-cycle read latency
package gig_regs_pkg;

  // register offsets
  localparam logic [4:0]  CTRL_OFFSET   = 5'h09;
  localparam logic [4:0]  STAT_OFFSET   = 5'h0a;

  // control register field positions
  localparam int          TM_HI         = 15;
  localparam int          TM_LO         = 13;
  localparam int          MAN_EN_BIT    = 12;
  localparam int          MAN_VAL_BIT   = 11;
  localparam int          PORT_TYPE_BIT = 10;
  localparam int          ADV_FD_BIT    = 9;
  localparam int          ADV_HD_BIT    = 8;

  // reset values and field encodings
  localparam logic [15:0] CTRL_RESET    = 16'h0300;
  localparam logic [2:0]  TM_NORMAL     = 3'h0;
  localparam logic [2:0]  TM_JIT_MASTER = 3'h2;
  localparam logic [2:0]  TM_JIT_SLAVE  = 3'h3;
  localparam logic [2:0]  TM_MAX        = 3'h4;
  localparam logic [7:0]  IDLE_MAX      = 8'hff;

  // settings that only apply on an update event
  typedef struct packed {
    logic manual_en;
    logic manual_master;
    logic port_master;
    logic adv_full;
    logic adv_half;
  } gig_cfg_s;

  // live link state from the negotiation and receive logic
  typedef struct packed {
    logic resolved_master;
    logic local_rx_ok;
    logic remote_rx_ok;
    logic lp_full;
    logic lp_half;
  } link_stat_s;

endpackage

// >>> sim/gig_regs_assertions.sv
// checker for the gigabit register pair
// assumes it is bound into the register block
`timescale 1ns/100ps
module gig_regs_checker (
  input wire logic i_clk, i_rst, i_rd, i_an_restart, i_link_down,
  input wire logic i_pd_main, i_pd_copper, i_role_fault, i_idle_error,
  input wire logic [4:0]  i_addr,
  input wire logic [15:0] o_rdata,
  input wire gig_regs_pkg::link_stat_s i_link,
  input wire gig_regs_pkg::gig_cfg_s   o_cfg,
  input wire logic [2:0]  o_test_mode,
  input wire logic o_tx_clk_from_rx, o_prefer_master, o_force_master,
  input wire logic o_force_slave, o_soft_reset, o_an_restart
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // status read, and one with no event beside it
  wire st = i_rd && i_addr == gig_regs_pkg::STAT_OFFSET;
  wire sq = st && !i_role_fault && !i_idle_error;
  a_mode_range: assert property (
    o_test_mode <= 3'h4) else $error("reserved test mode shown");
  a_tx_clk_sel: assert property (
    o_tx_clk_from_rx == (o_test_mode inside {3'h2, 3'h3})) else $error("txclk");
  a_restart_clear: assert property (
    i_an_restart |=> o_test_mode == 3'h0) else $error("test mode kept");
  a_cfg_pending: assert property (
    !(o_soft_reset || o_an_restart || i_link_down) |=> $stable(o_cfg))
    else $error("settings applied early");
  a_role_force: assert property (
    o_force_master == (o_cfg.manual_en && o_cfg.manual_master) &&
    o_force_slave == (o_cfg.manual_en && !o_cfg.manual_master))
    else $error("forced role wrong");
  a_prefer_ignore: assert property (
    o_prefer_master == (!o_cfg.manual_en && o_cfg.port_master))
    else $error("port preference wrong");
  a_status_live: assert property (
    st |=> o_rdata[14:10] == $past(i_link)) else $error("live status");
  a_read_clears: assert property (
    sq ##1 sq |=> o_rdata[15] == 1'b0 && o_rdata[7:0] == 8'h00)
    else $error("read did not clear");
  a_pd_exit: assert property (
    $fell(i_pd_main || i_pd_copper) |-> o_soft_reset && o_an_restart)
    else $error("power-up reset missing");
endmodule
bind gigabit_control_status_regs gig_regs_checker u_gig_regs_checker (.*);

// >>> sim/gigabit_control_status_regs_tb.sv
// self-checking bench for the gigabit register pair
// assumes the checker is bound in; the bench drives every input
`timescale 1ns/100ps
module gigabit_control_status_regs_tb;
  logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_soft_reset = 0;
  logic i_an_restart = 0, i_pd_main = 0, i_pd_copper = 0, rd_d = 0;
  logic i_link_down = 0, i_role_fault = 0, i_idle_error = 0;
  logic o_tx_clk_from_rx, o_prefer_master, o_force_master;
  logic o_force_slave, o_soft_reset, o_an_restart;
  logic [4:0]  i_addr = 0, app = 5'h03;
  logic [2:0]  o_test_mode;
  logic [15:0] i_wdata = 0, o_rdata, d, expq[$];
  gig_regs_pkg::link_stat_s i_link = '0;
  gig_regs_pkg::gig_cfg_s   o_cfg;
  int n_errors = 0, checked = 0;
  localparam logic [4:0] CA = gig_regs_pkg::CTRL_OFFSET;
  localparam logic [4:0] SA = gig_regs_pkg::STAT_OFFSET;
  gigabit_control_status_regs u_gigabit_control_status_regs (.*);
  always #50 i_clk = ~i_clk;
  // compare and count
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // one bus cycle; a read notes its expected data
  task automatic bus(logic w, logic [4:0] a, logic [15:0] v);
    if (!w) expq.push_back(v);
    {i_wr, i_rd, i_addr, i_wdata} <= {w, !w, a, v};
    @(posedge i_clk);
  endtask
  task automatic idle;
    {i_wr, i_rd} <= 2'b00;
    @(posedge i_clk);
    #1;
  endtask
  // k: soft reset, restart, link loss, power-down exit
  task automatic ev(int k);
    {i_pd_main, i_link_down, i_an_restart, i_soft_reset} <= 4'h1 << k;
    #1;
    chk("sreset", 16'(k == 0), 16'(o_soft_reset));
    chk("restart", 16'(k == 1), 16'(o_an_restart));
    @(posedge i_clk);
    {i_pd_main, i_link_down, i_an_restart, i_soft_reset} <= 4'h0;
    #1;
    chk("pdexit", 16'(k == 3), 16'(o_soft_reset && o_an_restart));
    @(posedge i_clk);
    #1;
  endtask
  // read data stands in the cycle after the strobe; look mid-cycle
  always @(posedge i_clk) rd_d <= i_rd;
  always @(negedge i_clk) begin
    if (rd_d) chk("rdata", expq.pop_front(), o_rdata);
  end
  initial begin
    void'($urandom(70));
    repeat (10) @(posedge i_clk);
    i_rst <= 0;
    bus(0, CA, gig_regs_pkg::CTRL_RESET);
    bus(0, 5'h03, 16'h0000);
    idle;
    chk("cfg", 16'h0003, 16'(o_cfg));
    for (int m = 0; m < 8; m++) begin
      d = {m[2:0], 13'($urandom)};
      bus(1, CA, d);
      bus(0, CA, d);
      idle;
      chk("mode", (m < 5) ? m : 0, o_test_mode);
      chk("txclk", m == 2 || m == 3, o_tx_clk_from_rx);
      chk("cfg", 16'(app), 16'(o_cfg));
    end
    $display("test mode test done");
    for (int k = 0; k < 4; k++) begin
      d = {3'h1, 13'($urandom)};
      bus(1, CA, d);
      idle;
      chk("held", 16'(app), 16'(o_cfg));
      ev(k);
      app = d[12:8];
      chk("cfg", 16'(app), 16'(o_cfg));
      chk("force", d[12] & d[11], o_force_master);
      chk("slave", d[12] & !d[11], o_force_slave);
      chk("prefer", !d[12] & d[10], o_prefer_master);
      bus(0, CA, {k[0] ? 3'h0 : 3'h1, d[12:0]});
      idle;
    end
    $display("pending settings test done");
    d = 16'($urandom);
    i_link <= d[4:0];
    repeat (260) begin
      {i_role_fault, i_idle_error} <= 2'b11;
      @(posedge i_clk);
      {i_role_fault, i_idle_error} <= 2'b00;
      @(posedge i_clk);
    end
    i_idle_error <= 1;
    bus(0, SA, {1'b1, d[4:0], 2'b00, 8'hff});
    i_idle_error <= 0;
    bus(0, SA, {1'b0, d[4:0], 2'b00, 8'h01});
    bus(0, SA, {1'b0, d[4:0], 2'b00, 8'h00});
    idle;
    $display("status test done");
    end_sim;
  end
  // hang guard
  initial begin
    #1000000;
    n_errors++;
    end_sim;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
endmodule
